// ===== rtl/msrc_pkg.sv
// Purpose: Shared constants and types of the master status and soft-reset register.
// Assumes: 16-bit host data and a 16-bit host word address.
// Notes: All offsets, bit positions and reset values live here.
package msrc_pkg;

	// Host word addresses.
	localparam logic [15:0] MSRC_CONFIG_OFS = 16'h0000;
	localparam logic [15:0] MSRC_STATUS_OFS = 16'h0001;

	// Bit positions inside the status and soft-reset register.
	localparam int MSRC_READY_BIT = 15;
	localparam int MSRC_AUTO_BIT = 13;
	localparam int MSRC_MON_RST_BIT = 12;
	localparam int MSRC_TERM_RST_BIT = 10;
	localparam int MSRC_MON_MSG_BIT = 7;

	// Value of the register after the master reset.
	localparam logic [15:0] MSRC_STATUS_RESET = 16'h0000;

	// One host access as presented by the serial host port.
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} msrc_host_req_s;

	// Soft-reset sequencing states.
	typedef enum logic [1:0] {
		MSRC_SLOT_IDLE,
		MSRC_SLOT_CLEAR,
		MSRC_SLOT_RUN
	} msrc_slot_e;

endpackage

// ===== rtl/msrc_reset_slot.sv
// Purpose: Sequences one soft reset from request to completion.
// Assumes: i_done is a pulse from the function's own reset logic.
// Notes: With CLEAR_FIRST set, a clear pulse precedes the start pulse.
`timescale 1ns/10ps
module msrc_reset_slot #(
	parameter bit CLEAR_FIRST = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic i_done,
	output logic o_busy,
	output logic o_clear_pulse,
	output logic o_start_pulse
);
	import msrc_pkg::*;

	msrc_slot_e state_q;
	msrc_slot_e state_d;
	logic clear_q;
	logic start_q;

	// Next state: a start is only taken from idle, so a running reset never restarts.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MSRC_SLOT_IDLE: begin
				if (i_start) begin
					state_d = CLEAR_FIRST ? MSRC_SLOT_CLEAR : MSRC_SLOT_RUN;
				end
			end
			MSRC_SLOT_CLEAR: begin
				state_d = MSRC_SLOT_RUN;
			end
			MSRC_SLOT_RUN: begin
				if (i_done) begin
					state_d = MSRC_SLOT_IDLE;
				end
			end
			default: begin
				state_d = MSRC_SLOT_IDLE;
			end
		endcase
	end

	// State and one-cycle pulses; clear fires on entry to CLEAR, start on entry to RUN.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q <= MSRC_SLOT_IDLE;
			clear_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			clear_q <= (state_q != MSRC_SLOT_CLEAR) && (state_d == MSRC_SLOT_CLEAR);
			start_q <= (state_q != MSRC_SLOT_RUN) && (state_d == MSRC_SLOT_RUN);
		end
	end

	assign o_busy = (state_q != MSRC_SLOT_IDLE);
	assign o_clear_pulse = clear_q;
	assign o_start_pulse = start_q;

endmodule

// ===== rtl/msrc_status_reset.sv
// Purpose: Master status and soft-reset register with host access lockout.
// Assumes: i_resetn is the synchronised master reset pin; host requests arrive decoded.
// Notes: Accesses other than this register are forwarded to the rest of the device.
// How it works
// - Register clears to zero on master reset; soft resets leave it unchanged.
// - Ready pin equals bit 15, low during auto-init, soft reset or self-test.
// - While not ready, accesses to other registers and memory are refused.
// - While not ready, every host read returns this register whatever the address.
// - Bit 13 holds the auto-init strap captured when master reset releases.
// - Bit 13 high means auto-init ran after master reset; low means not.
// - Writing one to bit 12 starts a monitor soft reset; zero does nothing.
// - Writing one to bit 10 clears terminal start-execution, then resets the terminal.
// - Each reset bit reads one until done, holding ready low meanwhile.
// - On completion the reset bit self-clears and ready rises again.
// - Bits 14, 11, 9 and 8 are read-only zero.
// - Bit 7 sets on a decoded monitored command, clears at message completion.
`timescale 1ns/10ps
module msrc_status_reset (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_auto_init_strap,
	input wire logic i_auto_init_busy,
	input wire logic i_self_test_busy,
	input wire logic i_mon_reset_done,
	input wire logic i_term_reset_done,
	input wire logic i_mon_cmd_valid,
	input wire logic i_mon_msg_done,
	input wire msrc_pkg::msrc_host_req_s i_host,
	input wire logic [15:0] i_fwd_rdata,
	output msrc_pkg::msrc_host_req_s o_fwd,
	output logic o_host_rvalid,
	output logic [15:0] o_host_rdata,
	output logic o_host_refused,
	output logic o_ready_pin,
	output logic o_mon_reset_start,
	output logic o_term_start_exec_clear,
	output logic o_term_reset_start
);
	import msrc_pkg::*;

	logic ready_q;
	logic rst_seen_q;
	logic strap_q;
	logic msg_q;
	logic rvalid_q;
	logic [15:0] rdata_q;
	logic mon_busy;
	logic term_busy;
	logic [15:0] status_word;
	logic hit_status;
	logic wr_status;
	logic mon_start;
	logic term_start;
	logic ready_d;
	logic rd_take;

	// Assembled word; all sources reset to zero, soft resets touch none of them.
	// Bit 13 reports whether auto-init was strapped on.
	assign status_word = {ready_q, 1'b0, strap_q, mon_busy, 1'b0, term_busy, 2'b00,
		msg_q, 7'h00};

	// Address decode and write strobe; writes are only taken while ready.
	assign hit_status = (i_host.addr == MSRC_STATUS_OFS);
	assign wr_status = i_host.req && i_host.we && hit_status && ready_q;
	// Starts only on a written one.
	// Ignored while the same reset runs.
	assign mon_start = wr_status && i_host.wdata[MSRC_MON_RST_BIT] && !mon_busy;
	assign term_start = wr_status && i_host.wdata[MSRC_TERM_RST_BIT] && !term_busy;

	// Ready drops for any of the busy causes, and already on the starting write.
	// A running soft reset keeps ready low until it is done.
	assign ready_d = !(i_auto_init_busy || i_self_test_busy || mon_busy || term_busy ||
		mon_start || term_start);

	// Forward only while ready and only for other addresses.
	assign o_fwd.req = i_host.req && ready_q && !hit_status;
	assign o_fwd.we = i_host.we;
	assign o_fwd.addr = i_host.addr;
	assign o_fwd.wdata = i_host.wdata;
	assign o_host_refused = i_host.req && !ready_q;
	assign rd_take = i_host.req && !i_host.we;

	// Monitor soft reset sequencer.
	msrc_reset_slot #(
		.CLEAR_FIRST(1'b0)
	) u_mon_slot (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_start(mon_start),
		.i_done(i_mon_reset_done),
		.o_busy(mon_busy),
		.o_clear_pulse(),
		.o_start_pulse(o_mon_reset_start)
	);

	// Terminal reset clears start-execution one cycle before its start pulse.
	msrc_reset_slot #(
		.CLEAR_FIRST(1'b1)
	) u_term_slot (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_start(term_start),
		.i_done(i_term_reset_done),
		.o_busy(term_busy),
		.o_clear_pulse(o_term_start_exec_clear),
		.o_start_pulse(o_term_reset_start)
	);

	// Readiness flop drives both the pin and bit 15.
	// It rises the cycle after the last busy cause ends.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ready_q <= MSRC_STATUS_RESET[MSRC_READY_BIT];
		end else begin
			ready_q <= ready_d;
		end
	end

	// Strap captured in the first clocked cycle after reset release.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rst_seen_q <= 1'b0;
			strap_q <= MSRC_STATUS_RESET[MSRC_AUTO_BIT];
		end else begin
			rst_seen_q <= 1'b1;
			if (!rst_seen_q) begin
				strap_q <= i_auto_init_strap;
			end
		end
	end

	// Message-in-process flag; a new command wins over a completion.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			msg_q <= MSRC_STATUS_RESET[MSRC_MON_MSG_BIT];
		end else if (i_mon_cmd_valid) begin
			msg_q <= 1'b1;
		end else if (i_mon_msg_done) begin
			msg_q <= 1'b0;
		end
	end

	// Read answer one cycle later; status word whenever not ready or addressed.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			rvalid_q <= rd_take;
			if (rd_take) begin
				rdata_q <= (!ready_q || hit_status) ? status_word : i_fwd_rdata;
			end
		end
	end

	assign o_host_rvalid = rvalid_q;
	assign o_host_rdata = rdata_q;
	assign o_ready_pin = status_word[MSRC_READY_BIT];

	// Checks on the register behaviour.
	property p_reset_clear;
		@(posedge i_ref_clk) !i_resetn |=> (status_word == 16'h0000);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("status not cleared");

	property p_busy_not_ready;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_auto_init_busy || i_self_test_busy) |=> !o_ready_pin;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready high while busy");

	property p_no_fwd_locked;
		@(posedge i_ref_clk) disable iff (!i_resetn) !o_ready_pin |-> !o_fwd.req;
	endproperty
	a_no_fwd_locked: assert property (p_no_fwd_locked) else $error("access forwarded while locked");

	property p_locked_read;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(rd_take && !o_ready_pin) |=> o_host_rvalid && (o_host_rdata == $past(status_word));
	endproperty
	a_locked_read: assert property (p_locked_read) else $error("locked read not status");

	property p_strap_hold;
		@(posedge i_ref_clk) disable iff (!i_resetn) rst_seen_q |=> $stable(strap_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap status changed");

	property p_mon_start;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(wr_status && i_host.wdata[MSRC_MON_RST_BIT] && !mon_busy)
		|=> o_mon_reset_start && status_word[MSRC_MON_RST_BIT] && !o_ready_pin;
	endproperty
	a_mon_start: assert property (p_mon_start) else $error("monitor reset not started");

	property p_term_order;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		term_start |=> o_term_start_exec_clear && !o_term_reset_start ##1 o_term_reset_start;
	endproperty
	a_term_order: assert property (p_term_order) else $error("terminal reset order wrong");

	property p_busy_holds_low;
		@(posedge i_ref_clk) disable iff (!i_resetn) (mon_busy || term_busy) |-> !o_ready_pin;
	endproperty
	a_busy_holds_low: assert property (p_busy_holds_low) else $error("ready high in reset");

	property p_self_clear;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(mon_busy && !o_mon_reset_start && i_mon_reset_done && !term_busy && !i_auto_init_busy
		&& !i_self_test_busy) |=> !status_word[MSRC_MON_RST_BIT] ##1 o_ready_pin;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("reset bit did not clear");

	property p_unused_zero;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(status_word[14] == 1'b0) && (status_word[11] == 1'b0) && (status_word[9:8] == 2'b00);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	property p_msg_set;
		@(posedge i_ref_clk) disable iff (!i_resetn) i_mon_cmd_valid |=> status_word[MSRC_MON_MSG_BIT];
	endproperty
	a_msg_set: assert property (p_msg_set) else $error("message flag not set");

	property p_no_restart;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(mon_busy && i_host.req && i_host.we && hit_status) |=> !o_mon_reset_start;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("monitor reset restarted");

	// Main scenarios.
	c_mon_done: cover property (@(posedge i_ref_clk) mon_busy ##1 !mon_busy ##1 o_ready_pin);
	c_term_done: cover property (@(posedge i_ref_clk) o_term_start_exec_clear ##[1:20] !term_busy);
	c_locked_read: cover property (@(posedge i_ref_clk) rd_take && !o_ready_pin && !hit_status);

endmodule

// ===== tb/msrc_far_model.sv
// Purpose: Behavioural model of the device logic behind the status register.
// Assumes: Forwarded accesses last one cycle; start pulses last one cycle.
// Notes: Reset completion comes i_dly cycles after the start pulse.
`timescale 1ns/10ps
module msrc_far_model (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire msrc_pkg::msrc_host_req_s i_fwd,
	input wire logic i_mon_start,
	input wire logic i_term_start,
	input wire logic [3:0] i_dly,
	output logic [15:0] o_rdata,
	output logic o_mon_done,
	output logic o_term_done
);
	import msrc_pkg::*;
	logic [15:0] mem_q [16];
	logic [15:0] last_q;
	logic [3:0] mcnt_q;
	logic [3:0] tcnt_q;

	// forwarded memory; an idle bus shows the inverse of the last word.
	assign o_rdata = i_fwd.req ? mem_q[i_fwd.addr[3:0]] : ~last_q;
	// completion pulses end each soft reset.
	assign o_mon_done = (mcnt_q == 4'h1);
	assign o_term_done = (tcnt_q == 4'h1);

	// Stores forwarded writes and counts down the running resets.
	always_ff @(posedge i_ref_clk) begin
		if (i_fwd.req && i_fwd.we) begin
			mem_q[i_fwd.addr[3:0]] <= i_fwd.wdata;
		end
		if (!i_resetn) begin
			last_q <= 16'h0000;
			mcnt_q <= 4'h0;
			tcnt_q <= 4'h0;
		end else begin
			last_q <= i_fwd.req ? o_rdata : last_q;
			mcnt_q <= i_mon_start ? i_dly : (mcnt_q != 4'h0 ? mcnt_q - 4'h1 : 4'h0);
			tcnt_q <= i_term_start ? i_dly : (tcnt_q != 4'h0 ? tcnt_q - 4'h1 : 4'h0);
		end
	end
endmodule

// ===== tb/test_master_status_reset_control.sv
// Purpose: Self-checking bench of the status and soft-reset register.
// Assumes: Host accesses use the decoded word port, one request per access.
// Notes: Reset completion is answered by the behavioural far-side model.
`timescale 1ns/10ps
module test_master_status_reset_control;
	import msrc_pkg::*;
	logic clk = 0, resetn = 0, strap = 0, aib = 1, stb = 0, cmdv = 0, msgd = 0;
	msrc_host_req_s host = '0;
	msrc_host_req_s fwd;
	logic [15:0] frd, rd, cyc = 0, clr_c = 0, st_c = 0, mst_n = 0;
	logic rv, refd, rdy, mst, tclr, tst, mdone, tdone;
	logic [3:0] dly = 4'hc;
	int mismatches = 0, total_checks = 0;

	msrc_status_reset i_dut (.i_ref_clk(clk), .i_resetn(resetn), .i_auto_init_strap(strap),
		.i_auto_init_busy(aib), .i_self_test_busy(stb), .i_mon_reset_done(mdone),
		.i_term_reset_done(tdone), .i_mon_cmd_valid(cmdv), .i_mon_msg_done(msgd),
		.i_host(host), .i_fwd_rdata(frd), .o_fwd(fwd), .o_host_rvalid(rv),
		.o_host_rdata(rd), .o_host_refused(refd), .o_ready_pin(rdy),
		.o_mon_reset_start(mst), .o_term_start_exec_clear(tclr), .o_term_reset_start(tst));
	msrc_far_model i_far (.i_ref_clk(clk), .i_resetn(resetn), .i_fwd(fwd),
		.i_mon_start(mst), .i_term_start(tst), .i_dly(dly), .o_rdata(frd),
		.o_mon_done(mdone), .o_term_done(tdone));

	// Clock of 10 ns period.
	initial begin
		forever #5 clk = ~clk;
	end

	// Records the terminal pulse cycles and counts monitor starts, mid-cycle where they settle.
	always @(negedge clk) begin
		cyc <= cyc + 16'h1;
		if (tclr === 1'b1) clr_c <= cyc;
		if (tst === 1'b1) st_c <= cyc;
		if (mst === 1'b1) mst_n <= mst_n + 16'h1;
	end

	task results;
		if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task check(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// One host access; read data is taken in the cycle the valid pulse stands.
	task acc(input logic we, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] r, output logic f);
		@(negedge clk);
		host = '{1'b1, we, a, d};
		#1 f = refd;
		@(negedge clk);
		r = (rv === 1'b1) ? rd : 16'hxxxx;
		host.req = 1'b0;
	endtask

	task rd_chk(input string n, input logic [15:0] a, input logic [15:0] e);
		logic [15:0] r;
		logic f;
		acc(1'b0, a, 16'h0, r, f);
		check(n, e, r);
	endtask

	task wr(input logic [15:0] a, input logic [15:0] d, input logic ef);
		logic [15:0] r;
		logic f;
		acc(1'b1, a, d, r, f);
		check("refused", {15'h0, ef}, {15'h0, f});
	endtask

	// wait for ready before normal access.
	task wait_ready;
		for (int i = 0; i < 60 && rdy !== 1'b1; i++) @(negedge clk);
		check("ready", 16'h1, {15'h0, rdy});
	endtask

	task mreset(input logic s);
		@(negedge clk);
		resetn = 0;
		strap = s;
		repeat (10) @(negedge clk);
		resetn = 1;
	endtask

	// Main sequence of host calls.
	initial begin
		mreset(1'b1);
		@(negedge clk);
		check("ready_lo", 16'h0, {15'h0, rdy});
		rd_chk("lock_read", 16'h0005, 16'h2000);
		wr(16'h0003, 16'h5555, 1'b1);
		aib = 0;
		wait_ready;
		rd_chk("status", 16'h0001, 16'ha000);
		wr(16'h0003, 16'h1234, 1'b0);
		rd_chk("mem", 16'h0003, 16'h1234);
		wr(16'h0001, 16'h0000, 1'b0);
		check("ready_zero", 16'h1, {15'h0, rdy});
		wr(16'h0001, 16'h1000, 1'b0);
		rd_chk("mon_busy", 16'h0003, 16'h3000);
		wr(16'h0001, 16'h1000, 1'b1);
		wait_ready;
		rd_chk("mon_done", 16'h0001, 16'ha000);
		check("mon_starts", 16'h1, mst_n);
		dly = 4'hf;
		wr(16'h0001, 16'h4f00, 1'b0);
		rd_chk("term_busy", 16'h0000, 16'h2400);
		wait_ready;
		check("clr_order", clr_c + 16'h1, st_c);
		rd_chk("term_done", 16'h0001, 16'ha000);
		@(negedge clk) cmdv = 1;
		@(negedge clk) cmdv = 0;
		rd_chk("msg_set", 16'h0001, 16'ha080);
		@(negedge clk) msgd = 1;
		@(negedge clk) msgd = 0;
		rd_chk("msg_clr", 16'h0001, 16'ha000);
		@(negedge clk) stb = 1;
		rd_chk("self_test", 16'h0003, 16'h2000);
		stb = 0;
		wait_ready;
		mreset(1'b0);
		wait_ready;
		rd_chk("strap_lo", 16'h0001, 16'h8000);
		results;
	end

	// Watchdog against a hang.
	initial begin
		#50us;
		mismatches++;
		results;
	end
endmodule
